/* File: logic/exec_slice_pkg.sv */
// ----------------------------------------------------------------------------
// Shared constants and types for the execute slice.
// ----------------------------------------------------------------------------
package exec_slice_pkg;

  // ----------------------------------------------------------------------------
  // Widths.
  // ----------------------------------------------------------------------------
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned FLAG_W  = 4;
  localparam int unsigned LEVEL_W = 3;

  // ----------------------------------------------------------------------------
  // Flag positions inside the flag vector.
  // ----------------------------------------------------------------------------
  localparam int unsigned FLAG_CARRY    = 0;
  localparam int unsigned FLAG_ZERO     = 1;
  localparam int unsigned FLAG_SIGN     = 2;
  localparam int unsigned FLAG_OVERFLOW = 3;

  // ----------------------------------------------------------------------------
  // Values after reset.
  // ----------------------------------------------------------------------------
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [3:0]  FLAGS_RST = 4'h0;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------------------
  // Operation codes presented with an issue strobe.
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    op_nop          = 3'h0,
    op_store_if_z   = 3'h1,
    op_select_store = 3'h2,
    op_subtract     = 3'h3,
    op_test         = 3'h4,
    op_undefined    = 3'h5,
    op_wait         = 3'h6,
    op_exchange     = 3'h7
  } op_t;

  // ----------------------------------------------------------------------------
  // Core run state; Gray coded along the run, halt, run path.
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    st_run  = 2'h0,
    st_halt = 2'h1
  } run_state_t;

endpackage

/* File: logic/logic_unit.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Subtract and AND unit with flag generation at byte or word width.
// ----------------------------------------------------------------------------
module logic_unit
  import exec_slice_pkg::*;
(
  // Operands, already aligned by the caller.
  input  wire logic [15:0] lhs,
  input  wire logic [15:0] rhs,
  // Mode.
  input  wire logic        wide,
  input  wire logic        do_and,
  // Results.
  output logic      [15:0] result,
  output logic      [3:0]  flags
);

  logic [16:0] diff;
  logic        msb;
  logic        zero;

  // Result and flags; width picks the sign bit and the zero test.
  always_comb begin
    diff   = {1'b0, lhs} - {1'b0, rhs};
    result = do_and ? (lhs & rhs) : diff[15:0];
    msb    = wide ? result[15] : result[7];
    zero   = wide ? (result == WORD_RST) : (result[7:0] == BYTE_ZERO);
    flags  = FLAGS_RST;
    flags[FLAG_ZERO] = zero;
    flags[FLAG_SIGN] = msb;
    if (!do_and) begin
      // Carry means no borrow; overflow when operand signs differ and the sign flips.
      flags[FLAG_CARRY]    = wide ? ~diff[16] : (lhs[7:0] >= rhs[7:0]);
      flags[FLAG_OVERFLOW] = wide ? ((lhs[15] ^ rhs[15]) & (lhs[15] ^ msb))
                                  : ((lhs[7] ^ rhs[7]) & (lhs[7] ^ msb));
    end
  end

endmodule

`default_nettype wire

/* File: logic/exec_slice.sv */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Conditional store writes source to destination only when zero flag is 1.
// - Select store writes first source if zero flag is 1, else second source.
// - Subtract writes destination minus source back into destination.
// - Byte subtract or test into address register zero-extends source, runs 16-bit.
// - Byte subtract or test from address register uses its low 8 bits only.
// - Test sets zero and sign from the AND of source and destination, clears carry and overflow.
// - Undefined-opcode instruction raises the undefined-instruction interrupt.
// - That interrupt ignores interrupt enable and processor priority level.
// - Wait halts until a higher-priority interrupt is acknowledged or reset.
// - Exchange swaps source and destination contents.
// - Byte exchange into address register: zero-extended source in, low byte out.
module exec_slice
  import exec_slice_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  // Instruction issue.
  input  wire logic                 issue,
  input  wire op_t                  op,
  input  wire logic                 byte_size,
  input  wire logic                 dest_is_addr,
  input  wire logic                 src_is_addr,
  // Operand values read from registers or memory.
  input  wire logic [WORD_W-1:0]    first_source,
  input  wire logic [WORD_W-1:0]    second_source,
  input  wire logic [WORD_W-1:0]    dest_value,
  input  wire logic [FLAG_W-1:0]    flags_in,
  // Interrupt context.
  input  wire logic                 int_enable,
  input  wire logic [LEVEL_W-1:0]   processor_priority_level,
  input  wire logic                 irq_pending,
  input  wire logic [LEVEL_W-1:0]   irq_level,
  // Write-back to the destination operand.
  output logic                      dest_we_q,
  output logic      [WORD_W-1:0]    dest_data_q,
  // Write-back to the source operand.
  output logic                      src_we_q,
  output logic      [WORD_W-1:0]    src_data_q,
  // Flag write-back.
  output logic                      flags_we_q,
  output logic      [FLAG_W-1:0]    flags_q,
  // Interrupt and run status.
  output logic                      undef_trap_q,
  output logic                      irq_ack_q,
  output logic                      halted_q,
  output logic                      ready_q
);

  // ----------------------------------------------------------------------------
  // Operand alignment helpers.
  // ----------------------------------------------------------------------------

  // Byte-size source: only the low byte counts, zero-extended to a word.
  function automatic logic [15:0] byte_source(input logic [15:0] value);
    byte_source = {BYTE_ZERO, value[7:0]};
  endfunction

  // Merges a byte result into a word, keeping the destination's upper byte.
  function automatic logic [15:0] merge_byte(input logic [15:0] keep,
                                             input logic [15:0] value);
    merge_byte = {keep[15:8], value[7:0]};
  endfunction

  // Value written to a destination for a plain store or an exchange.
  function automatic logic [15:0] store_value(input logic        as_byte,
                                              input logic        to_addr,
                                              input logic [15:0] keep,
                                              input logic [15:0] value);
    if (!as_byte) begin
      store_value = value;
    end else if (to_addr) begin
      store_value = byte_source(value);
    end else begin
      store_value = merge_byte(keep, value);
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Arithmetic operand preparation.
  // ----------------------------------------------------------------------------
  logic        wide_op;
  logic [15:0] alu_rhs;
  logic [15:0] alu_lhs;
  logic [15:0] alu_result;
  logic [3:0]  alu_flags;

  // Byte mode into an address register widens to 16 bits.
  always_comb begin
    wide_op = !byte_size || dest_is_addr;
    alu_rhs = byte_size ? byte_source(first_source) : first_source;
    alu_lhs = dest_value;
  end

  // Subtract and AND datapath.
  logic_unit u_logic_unit (
    .lhs    (alu_lhs),
    .rhs    (alu_rhs),
    .wide   (wide_op),
    .do_and (op == op_test),
    .result (alu_result),
    .flags  (alu_flags)
  );

  // ----------------------------------------------------------------------------
  // Run state and write-back registers.
  // ----------------------------------------------------------------------------
  run_state_t          state_q;
  run_state_t          state_d;
  logic                dest_we_d;
  logic [WORD_W-1:0]   dest_data_d;
  logic                src_we_d;
  logic [WORD_W-1:0]   src_data_d;
  logic                flags_we_d;
  logic [FLAG_W-1:0]   flags_d;
  logic                undef_trap_d;
  logic                irq_ack_d;
  logic                take;
  logic                zero_set;
  logic                wake;

  // Next-state and write-back decode for one issued instruction.
  always_comb begin
    state_d      = state_q;
    dest_we_d    = 1'b0;
    dest_data_d  = dest_data_q;
    src_we_d     = 1'b0;
    src_data_d   = src_data_q;
    flags_we_d   = 1'b0;
    flags_d      = flags_q;
    undef_trap_d = 1'b0;
    irq_ack_d    = 1'b0;
    zero_set     = flags_in[FLAG_ZERO];
    take         = issue && (state_q == st_run);
    wake         = irq_pending && int_enable && (irq_level > processor_priority_level);
    case (state_q)
      st_run: begin
        if (take) begin
          case (op)
            op_store_if_z: begin
              dest_we_d   = zero_set;
              dest_data_d = store_value(byte_size, dest_is_addr, dest_value, first_source);
            end
            op_select_store: begin
              dest_we_d   = 1'b1;
              dest_data_d = zero_set
                          ? store_value(byte_size, dest_is_addr, dest_value, first_source)
                          : store_value(byte_size, dest_is_addr, dest_value, second_source);
            end
            op_subtract: begin
              dest_we_d   = 1'b1;
              dest_data_d = wide_op ? alu_result : merge_byte(dest_value, alu_result);
              flags_we_d  = 1'b1;
              flags_d     = alu_flags;
            end
            op_test: begin
              flags_we_d  = 1'b1;
              flags_d     = alu_flags;
            end
            op_undefined: begin
              undef_trap_d = 1'b1;
            end
            op_wait: begin
              state_d = st_halt;
            end
            op_exchange: begin
              dest_we_d   = 1'b1;
              dest_data_d = store_value(byte_size, dest_is_addr, dest_value, first_source);
              src_we_d    = 1'b1;
              src_data_d  = byte_size ? merge_byte(first_source, dest_value) : dest_value;
            end
            default: begin
              state_d = st_run;
            end
          endcase
        end
      end
      st_halt: begin
        if (wake) begin
          irq_ack_d = 1'b1;
          state_d   = st_run;
        end
      end
      default: begin
        state_d = st_run;
      end
    endcase
  end

  // Registers; the undefined trap is raised without looking at enable or level.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q      <= st_run;
      dest_we_q    <= 1'b0;
      dest_data_q  <= WORD_RST;
      src_we_q     <= 1'b0;
      src_data_q   <= WORD_RST;
      flags_we_q   <= 1'b0;
      flags_q      <= FLAGS_RST;
      undef_trap_q <= 1'b0;
      irq_ack_q    <= 1'b0;
      halted_q     <= 1'b0;
      ready_q      <= 1'b0;
    end else if (clk_en) begin
      state_q      <= state_d;
      dest_we_q    <= dest_we_d;
      dest_data_q  <= dest_data_d;
      src_we_q     <= src_we_d;
      src_data_q   <= src_data_d;
      flags_we_q   <= flags_we_d;
      flags_q      <= flags_d;
      undef_trap_q <= undef_trap_d;
      irq_ack_q    <= irq_ack_d;
      halted_q     <= (state_d == st_halt);
      ready_q      <= (state_d == st_run);
    end
  end

endmodule

`default_nettype wire

/* File: testbench/exec_slice_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------
// Port checker for the execute slice.
// --------------------------------------------------------
module exec_slice_monitor
  import exec_slice_pkg::*;
(
  // Clock and control.
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        clk_en,
  input wire logic        issue,
  input wire op_t         op,
  input wire logic        byte_size,
  input wire logic        dest_is_addr,
  input wire logic [15:0] first_source,
  input wire logic [15:0] second_source,
  input wire logic [15:0] dest_value,
  input wire logic [3:0]  flags_in,
  input wire logic        int_enable,
  // Results.
  input wire logic        dest_we_q,
  input wire logic [15:0] dest_data_q,
  input wire logic        src_we_q,
  input wire logic [15:0] src_data_q,
  input wire logic        flags_we_q,
  input wire logic        undef_trap_q,
  input wire logic        halted_q,
  input wire logic        ready_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // An issue is taken only while the slice is running.
  wire logic tk;
  assign tk = clk_en && issue && ready_q;
  AST_STORE_Z: assert property (tk && op == op_store_if_z && flags_in[1] && !byte_size
    |=> dest_we_q && dest_data_q == $past(first_source)) else $error("store lost");
  AST_STORE_NZ: assert property (tk && op == op_store_if_z && !flags_in[1]
    |=> !dest_we_q) else $error("store without zero");
  AST_SELECT: assert property (tk && op == op_select_store && !byte_size
    |=> dest_data_q == ($past(flags_in[1]) ? $past(first_source) : $past(second_source)))
    else $error("select wrong");
  AST_SUB: assert property (tk && op == op_subtract && !byte_size
    |=> dest_we_q && dest_data_q == $past(dest_value) - $past(first_source))
    else $error("difference wrong");
  AST_BYTE_SUB: assert property (tk && op == op_subtract && byte_size && dest_is_addr
    |=> dest_data_q == $past(dest_value) - ($past(first_source) & 16'h00ff))
    else $error("byte difference wrong");
  AST_TEST: assert property (tk && op == op_test
    |=> flags_we_q && !dest_we_q && !src_we_q) else $error("test wrote operand");
  AST_UNDEF: assert property (tk && op == op_undefined |=> undef_trap_q)
    else $error("trap missing");
  AST_WAIT: assert property (tk && op == op_wait |=> halted_q && !ready_q)
    else $error("no halt");
  AST_HOLD: assert property (halted_q && clk_en && !int_enable |=> halted_q)
    else $error("woke while masked");
  AST_XCHG: assert property (tk && op == op_exchange && byte_size && dest_is_addr
    |=> dest_data_q == ($past(first_source) & 16'h00ff)
        && src_data_q[7:0] == $past(dest_value[7:0])) else $error("exchange wrong");
endmodule

bind exec_slice exec_slice_monitor mon (.*);

`default_nettype wire

/* File: testbench/cpu_instruction_semantics_test.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, s); end end

// --------------------------------------------------------
// Self-checking bench for the execute slice.
// --------------------------------------------------------
module cpu_instruction_semantics_test;
  import exec_slice_pkg::*;
  logic mclk = 0, resetn = 0, clk_en = 1, issue = 0, bs = 0, da = 0, sa = 0;
  logic ie = 0, irq = 0, asleep = 0, took = 0;
  op_t op = op_nop;
  logic [15:0] f1 = 0, f2 = 0, dv = 0, dd, sd, e;
  logic [3:0] fl = 0, fq;
  logic [2:0] ppl = 0, lvl = 0;
  logic dwe, swe, fwe, trap, ack, halted, ready;
  int n_fail = 0, tests_run = 0;
  logic [15:0] qd[$], qs[$];
  logic [3:0] qf[$];
  logic [1:0] qe[$];

  always #10 mclk = ~mclk;

  exec_slice dut (.mclk(mclk), .resetn(resetn), .clk_en(clk_en), .issue(issue), .op(op),
    .byte_size(bs), .dest_is_addr(da), .src_is_addr(sa), .first_source(f1),
    .second_source(f2), .dest_value(dv), .flags_in(fl), .int_enable(ie),
    .processor_priority_level(ppl), .irq_pending(irq), .irq_level(lvl),
    .dest_we_q(dwe), .dest_data_q(dd), .src_we_q(swe), .src_data_q(sd),
    .flags_we_q(fwe), .flags_q(fq), .undef_trap_q(trap), .irq_ack_q(ack),
    .halted_q(halted), .ready_q(ready));

  // A byte result into a plain destination keeps the upper byte.
  function automatic logic [15:0] fit(logic [15:0] r, d, logic b, a);
    return (b && !a) ? {d[15:8], r[7:0]} : r;
  endfunction

  // Issues one instruction and notes the results it must produce.
  task automatic go(op_t o, logic b, a, logic [15:0] x, y, d, logic [3:0] f);
    logic [15:0] s, r;
    logic w;
    s = b ? {8'h00, x[7:0]} : x;
    w = !b || a;
    r = d - s;
    @(posedge mclk);
    issue <= 1; op <= o; bs <= b; da <= a; sa <= $urandom;
    f1 <= x; f2 <= y; dv <= d; fl <= f;
    if (!asleep) case (o)
      op_store_if_z: if (f[1]) qd.push_back(fit(s, d, b, a));
      op_select_store: qd.push_back(fit(f[1] ? s : (b ? {8'h00, y[7:0]} : y), d, b, a));
      op_subtract: begin
        qd.push_back(fit(r, d, b, a));
        qf.push_back(w ? {(d[15] ^ s[15]) & (r[15] ^ d[15]), r[15], r == 16'h0, d >= s}
          : {(d[7] ^ s[7]) & (r[7] ^ d[7]), r[7], r[7:0] == 8'h00, d[7:0] >= s[7:0]});
      end
      op_test: begin
        r = d & s;
        qf.push_back(w ? {1'b0, r[15], r == 16'h0, 1'b0} : {1'b0, r[7], r[7:0] == 8'h00, 1'b0});
      end
      op_exchange: begin
        qd.push_back(fit(s, d, b, a));
        qs.push_back(b ? {x[15:8], d[7:0]} : d);
      end
      op_undefined: qe.push_back(2'h1);
      default: ;
    endcase
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge mclk) issue <= 0;
  endtask

  // Notes whether the last edge was enabled, so a frozen pulse is checked only once.
  always @(posedge mclk) took <= clk_en;

  // Takes the oldest note off a queue whenever a result appears.
  always @(negedge mclk) if (resetn && took) begin
    if (dwe) begin e = qd.size() ? qd.pop_front() : 'x; `CHK("dest", e, dd) end
    if (swe) begin e = qs.size() ? qs.pop_front() : 'x; `CHK("src", e, sd) end
    if (fwe) begin e = qf.size() ? 16'(qf.pop_front()) : 'x; `CHK("flags", e, 16'(fq)) end
    if (trap) begin e = qe.size() ? 16'(qe.pop_front()) : 'x; `CHK("trap", e, 16'h1) end
    if (ack) begin e = qe.size() ? 16'(qe.pop_front()) : 'x; `CHK("ack", e, 16'h2) end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    op_t o;
    int k;
    void'($urandom(32'h2e68876c));
    idle(3);
    resetn <= 1;
    idle(2);
    // Random back-to-back traffic, trap taken at any enable and level.
    repeat (300) begin
      o = op_t'($urandom_range(7, 1));
      if (o == op_wait) o = op_undefined;
      ie <= $urandom; ppl <= $urandom;
      go(o, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom);
    end
    idle(3);
    // Enable low after the issue edge: the write pulse and its data stand frozen.
    go(op_subtract, 0, 0, 16'h0003, 0, 16'h0005, 0);
    @(posedge mclk);
    issue <= 0;
    clk_en <= 0;
    idle(2);
    @(negedge mclk) `CHK("freeze", 17'h1_0002, {dwe, dd})
    @(posedge mclk);
    clk_en <= 1;
    idle(2);
    // Halt, ignore issues, stay asleep on a low level or when masked.
    ppl <= 3'h3;
    go(op_wait, 0, 0, 0, 0, 0, 0);
    asleep = 1;
    go(op_subtract, 0, 0, 16'h0001, 0, 16'h0005, 0);
    idle(2);
    @(negedge mclk) `CHK("halt", 2'b10, {halted, ready})
    irq <= 1; lvl <= 3'h3; ie <= 1;
    idle(4);
    lvl <= 3'h5; ie <= 0;
    idle(4);
    @(negedge mclk) `CHK("asleep", 1'b1, halted)
    qe.push_back(2'h2);
    ie <= 1;
    k = 0;
    while (halted !== 1'b0 && k < 10) begin @(negedge mclk); k++; end
    if (k == 10) begin
      `CHK("wake", 1'b0, halted)
      end_of_test();
    end
    irq <= 0; asleep = 0;
    idle(2);
    @(negedge mclk) `CHK("run", 1'b1, ready)
    // Reset also leaves halt.
    go(op_wait, 0, 0, 0, 0, 0, 0);
    idle(2);
    @(negedge mclk) `CHK("halt again", 1'b1, halted)
    @(posedge mclk) resetn <= 0;
    @(negedge mclk) `CHK("reset", 1'b0, halted)
    idle(1);
    resetn <= 1;
    idle(3);
    `CHK("left", 0, qd.size() + qs.size() + qf.size() + qe.size())
    end_of_test();
  end
endmodule

`default_nettype wire
